/* File: hw/nvsc_host.sv */
`timescale 1ns/1ps
// How it works
// - write with both strobes low, address held stable
// - output gate kept high during writes
// - store needs six ordered sequence reads
// - write strobe high through all six steps
// - each sequence address clocked by chip enable
// - write strobe high when power-up recall ends
module nvsc_host #(
  parameter int STORE_CYCLES = nvsc_pkg::STORE_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // user request port
  input wire logic req_valid,
  input wire nvsc_pkg::nvsc_req_t req,
  output logic req_ready,
  output logic rsp_valid,
  output logic [nvsc_pkg::DATA_W-1:0] rsp_data,
  output logic busy,
  // supply sense, high while supply is above the sense level
  input wire logic supply_ok,
  // memory pins
  output nvsc_pkg::nvsc_pins_t mem,
  input wire logic [nvsc_pkg::DATA_W-1:0] data_pins_in
);
  localparam logic [nvsc_pkg::CNT_W-1:0] ACC_LD =
    nvsc_pkg::CNT_W'(nvsc_pkg::ACCESS_CYC - 1);
  localparam logic [nvsc_pkg::CNT_W-1:0] WR_LD =
    nvsc_pkg::CNT_W'(nvsc_pkg::WRITE_CYC - 1);
  localparam logic [nvsc_pkg::CNT_W-1:0] OFF_LD =
    nvsc_pkg::CNT_W'(nvsc_pkg::OFF_CYC - 1);
  localparam logic [nvsc_pkg::CNT_W-1:0] RCL_LD =
    nvsc_pkg::CNT_W'(nvsc_pkg::RECALL_CYC - 1);
  localparam logic [nvsc_pkg::CNT_W-1:0] STO_LD =
    nvsc_pkg::CNT_W'(STORE_CYCLES - 1);

  nvsc_pkg::nvsc_regs_t s_r;
  nvsc_pkg::nvsc_regs_t s_nxt;
  logic nv_op;

  assign nv_op = (s_r.op == nvsc_pkg::OP_STORE) ||
                 (s_r.op == nvsc_pkg::OP_RECALL);
  // requests only taken in idle; handshake is combinational
  assign req_ready = (s_r.st == nvsc_pkg::ST_IDLE) && supply_ok;
  assign rsp_valid = s_r.done;
  assign rsp_data = s_r.rdata;
  assign busy = (s_r.st != nvsc_pkg::ST_IDLE);
  assign mem = s_r.pins;

  // next state: one sequencer drives every pin from flip-flops
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    case (s_r.st)
      nvsc_pkg::ST_PWRUP:
      begin
        // strobes parked high so recall never ends in a write
        s_nxt.pins.chip_en_n = 1'b1;
        s_nxt.pins.write_en_n = 1'b1;
        s_nxt.pins.out_en_n = 1'b1;
        s_nxt.pins.data_pins_oe = 1'b0;
        if (!supply_ok)
          s_nxt.cnt = RCL_LD;
        else if (s_r.cnt == '0)
          s_nxt.st = nvsc_pkg::ST_IDLE;
        else
          s_nxt.cnt = s_r.cnt - 1'b1;
      end
      nvsc_pkg::ST_IDLE:
      begin
        if (req_valid && req_ready)
        begin
          s_nxt.st = nvsc_pkg::ST_ACT;
          s_nxt.op = req.op;
          s_nxt.step = '0;
          s_nxt.pins.chip_en_n = 1'b0;
          if (req.op == nvsc_pkg::OP_WRITE)
          begin
            s_nxt.pins.address_inputs = req.addr;
            s_nxt.pins.write_en_n = 1'b0;
            s_nxt.pins.out_en_n = 1'b1;
            s_nxt.pins.data_pins_out = req.wdata;
            s_nxt.pins.data_pins_oe = 1'b1;
            s_nxt.cnt = WR_LD;
          end
          else if (req.op == nvsc_pkg::OP_READ)
          begin
            s_nxt.pins.address_inputs = req.addr;
            s_nxt.pins.write_en_n = 1'b1;
            s_nxt.pins.out_en_n = 1'b0;
            s_nxt.cnt = ACC_LD;
          end
          else
          begin
            // gate left high: the sequence does not need the outputs
            s_nxt.pins.address_inputs =
              nvsc_pkg::nvsc_seq_addr(3'h0, req.op);
            s_nxt.pins.write_en_n = 1'b1;
            s_nxt.pins.out_en_n = 1'b1;
            s_nxt.cnt = ACC_LD;
          end
        end
      end
      nvsc_pkg::ST_ACT:
      begin
        if (s_r.cnt != '0)
          s_nxt.cnt = s_r.cnt - 1'b1;
        else
        begin
          // full access time held so read data is valid at the edge
          if (s_r.op == nvsc_pkg::OP_READ)
            s_nxt.rdata = data_pins_in;
          s_nxt.pins.chip_en_n = 1'b1;
          s_nxt.pins.write_en_n = 1'b1;
          s_nxt.pins.out_en_n = 1'b1;
          s_nxt.st = nvsc_pkg::ST_REC;
          s_nxt.cnt = OFF_LD;
        end
      end
      nvsc_pkg::ST_REC:
      begin
        // data held one cycle past the write strobe, address longer
        s_nxt.pins.data_pins_oe = 1'b0;
        if (s_r.cnt != '0)
          s_nxt.cnt = s_r.cnt - 1'b1;
        else if (nv_op && s_r.step != nvsc_pkg::LAST_STEP)
        begin
          // next step back to back, nothing else interleaved
          s_nxt.step = s_r.step + 1'b1;
          s_nxt.pins.address_inputs =
            nvsc_pkg::nvsc_seq_addr(s_r.step + 1'b1, s_r.op);
          s_nxt.pins.chip_en_n = 1'b0;
          s_nxt.st = nvsc_pkg::ST_ACT;
          s_nxt.cnt = ACC_LD;
        end
        else if (nv_op)
        begin
          // device is deaf now; wait out the longest cycle time
          s_nxt.st = nvsc_pkg::ST_NVWAIT;
          s_nxt.cnt = (s_r.op == nvsc_pkg::OP_STORE) ?
            STO_LD : RCL_LD;
        end
        else
        begin
          s_nxt.done = 1'b1;
          s_nxt.st = nvsc_pkg::ST_IDLE;
        end
      end
      nvsc_pkg::ST_NVWAIT:
      begin
        if (s_r.cnt != '0)
          s_nxt.cnt = s_r.cnt - 1'b1;
        else
        begin
          s_nxt.done = 1'b1;
          s_nxt.st = nvsc_pkg::ST_IDLE;
        end
      end
      default:
        s_nxt.st = nvsc_pkg::ST_PWRUP;
    endcase
    // supply loss kills any store; device recalls on return
    if (!supply_ok && s_r.st != nvsc_pkg::ST_PWRUP)
    begin
      s_nxt.st = nvsc_pkg::ST_PWRUP;
      s_nxt.cnt = RCL_LD;
      s_nxt.pins.chip_en_n = 1'b1;
      s_nxt.pins.write_en_n = 1'b1;
      s_nxt.pins.out_en_n = 1'b1;
      s_nxt.pins.data_pins_oe = 1'b0;
      s_nxt.done = 1'b0;
    end
  end

  // state register; clock enable freezes everything
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_r <= '0;
      s_r.st <= nvsc_pkg::ST_PWRUP;
      s_r.cnt <= RCL_LD;
      s_r.pins.chip_en_n <= 1'b1;
      s_r.pins.write_en_n <= 1'b1;
      s_r.pins.out_en_n <= 1'b1;
    end
    else if (clk_en)
      s_r <= s_nxt;
  end

  sequence s_read_pulse;
    !s_r.pins.chip_en_n [*7];
  endsequence

  sequence s_gap;
    s_r.pins.chip_en_n [*4];
  endsequence

  property p_we_high_seq;
    @(posedge clk) disable iff (!rst_n)
    (nv_op && (s_r.st == nvsc_pkg::ST_ACT || s_r.st == nvsc_pkg::ST_REC))
      |-> s_r.pins.write_en_n;
  endproperty
  a_we_high_seq: assert property (p_we_high_seq)
    else $error("write strobe low inside sequence");

  property p_oe_high_write;
    @(posedge clk) disable iff (!rst_n)
    !s_r.pins.write_en_n |-> s_r.pins.out_en_n && s_r.pins.data_pins_oe;
  endproperty
  a_oe_high_write: assert property (p_oe_high_write)
    else $error("gate low or data undriven during write");

  property p_addr_stable;
    @(posedge clk) disable iff (!rst_n)
    (!s_r.pins.chip_en_n && $past(!s_r.pins.chip_en_n))
      |-> $stable(s_r.pins.address_inputs);
  endproperty
  a_addr_stable: assert property (p_addr_stable)
    else $error("address moved while selected");

  property p_read_pulse;
    // a supply loss cuts a pulse short on purpose
    @(posedge clk) disable iff (!rst_n || !supply_ok)
    $fell(s_r.pins.chip_en_n) && s_r.pins.write_en_n |-> s_read_pulse;
  endproperty
  a_read_pulse: assert property (p_read_pulse)
    else $error("read chip enable pulse too short");

  property p_gap;
    @(posedge clk) disable iff (!rst_n)
    $rose(s_r.pins.chip_en_n) |-> s_gap;
  endproperty
  a_gap: assert property (p_gap)
    else $error("chip enable high time too short");

  property p_seq_first;
    @(posedge clk) disable iff (!rst_n)
    $fell(s_r.pins.chip_en_n) && nv_op && s_r.step == 3'h0
      |-> s_r.pins.address_inputs == nvsc_pkg::SEQ_A0;
  endproperty
  a_seq_first: assert property (p_seq_first)
    else $error("sequence does not open at first address");

  property p_seq_last;
    @(posedge clk) disable iff (!rst_n)
    $fell(s_r.pins.chip_en_n) && s_r.step == nvsc_pkg::LAST_STEP
      |-> s_r.pins.address_inputs == ((s_r.op == nvsc_pkg::OP_STORE) ?
          nvsc_pkg::STORE_A5 : nvsc_pkg::RECALL_A5);
  endproperty
  a_seq_last: assert property (p_seq_last)
    else $error("sixth address does not match operation");

  property p_pwrup_quiet;
    @(posedge clk) disable iff (!rst_n)
    s_r.st == nvsc_pkg::ST_PWRUP
      |-> s_r.pins.write_en_n && s_r.pins.chip_en_n && !req_ready;
  endproperty
  a_pwrup_quiet: assert property (p_pwrup_quiet)
    else $error("strobe active during power-up recall");

  property p_nv_quiet;
    @(posedge clk) disable iff (!rst_n)
    $rose(s_r.st == nvsc_pkg::ST_NVWAIT) |->
      (s_r.pins.chip_en_n && !s_r.done) [*8];
  endproperty
  a_nv_quiet: assert property (p_nv_quiet)
    else $error("access during nonvolatile cycle");
endmodule : nvsc_host

/* File: hw/nvsc_pkg.sv */
package nvsc_pkg;
  // bus widths
  localparam int ADDR_W = 13;
  localparam int DATA_W = 8;
  localparam int CNT_W = 21;
  localparam int STEP_W = 3;
  // clock and pin timing, times as printed
  localparam int CLK_NS = 8;
  localparam int T_ACCESS_NS = 55;
  localparam int T_WRITE_NS = 45;
  localparam int T_OFF_NS = 25;
  localparam int T_RECALL_US = 20;
  localparam int T_STORE_MS = 10;
  // least times round up, waits cover the longest time
  localparam int ACCESS_CYC = (T_ACCESS_NS + CLK_NS - 1) / CLK_NS;
  localparam int WRITE_CYC = (T_WRITE_NS + CLK_NS - 1) / CLK_NS;
  localparam int OFF_CYC = (T_OFF_NS + CLK_NS - 1) / CLK_NS;
  localparam int RECALL_CYC = (T_RECALL_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int STORE_CYC = (T_STORE_MS * 1000000 + CLK_NS - 1) / CLK_NS;
  localparam logic [STEP_W-1:0] LAST_STEP = 3'h5;
  // initiation sequence addresses
  localparam logic [ADDR_W-1:0] SEQ_A0 = 13'h0000;
  localparam logic [ADDR_W-1:0] SEQ_A1 = 13'h1555;
  localparam logic [ADDR_W-1:0] SEQ_A2 = 13'h0AAA;
  localparam logic [ADDR_W-1:0] SEQ_A3 = 13'h1FFF;
  localparam logic [ADDR_W-1:0] SEQ_A4 = 13'h10F0;
  localparam logic [ADDR_W-1:0] STORE_A5 = 13'h0F0F;
  localparam logic [ADDR_W-1:0] RECALL_A5 = 13'h0F0E;

  typedef enum logic [1:0] {
    OP_READ = 2'h0,
    OP_WRITE = 2'h1,
    OP_STORE = 2'h2,
    OP_RECALL = 2'h3
  } nvsc_op_t;

  // gray along power-up, idle, strobe, recover, nonvolatile wait
  typedef enum logic [2:0] {
    ST_PWRUP = 3'h0,
    ST_IDLE = 3'h1,
    ST_ACT = 3'h3,
    ST_REC = 3'h2,
    ST_NVWAIT = 3'h6
  } nvsc_state_t;

  typedef struct packed {
    nvsc_op_t op;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } nvsc_req_t;

  typedef struct packed {
    logic chip_en_n;
    logic write_en_n;
    logic out_en_n;
    logic [ADDR_W-1:0] address_inputs;
    logic [DATA_W-1:0] data_pins_out;
    logic data_pins_oe;
  } nvsc_pins_t;

  typedef struct packed {
    nvsc_state_t st;
    nvsc_op_t op;
    logic [CNT_W-1:0] cnt;
    logic [STEP_W-1:0] step;
    nvsc_pins_t pins;
    logic [DATA_W-1:0] rdata;
    logic done;
  } nvsc_regs_t;

  // address of a given step of the store or recall sequence
  function automatic logic [ADDR_W-1:0] nvsc_seq_addr(
    input logic [STEP_W-1:0] step,
    input nvsc_op_t op
  );
    case (step)
      3'h0: nvsc_seq_addr = SEQ_A0;
      3'h1: nvsc_seq_addr = SEQ_A1;
      3'h2: nvsc_seq_addr = SEQ_A2;
      3'h3: nvsc_seq_addr = SEQ_A3;
      3'h4: nvsc_seq_addr = SEQ_A4;
      default: nvsc_seq_addr = (op == OP_STORE) ? STORE_A5 : RECALL_A5;
    endcase
  endfunction : nvsc_seq_addr
endpackage : nvsc_pkg

/* File: verification/nvsc_dev_model.sv */
`timescale 1ns/1ps
// behavioural byte-wide memory with a shadow copy behind it
module nvsc_dev_model #(
  parameter int STORE_NS = 150,
  parameter int RECALL_NS = 19000
) (
  // host pins
  input wire nvsc_pkg::nvsc_pins_t mem,
  input wire logic supply_ok,
  // data pins as the host sees them, and a count of misuse
  output logic [7:0] data_pins_in,
  output int clashes
);
  logic [7:0] ram [8192];
  logic [7:0] nvm [8192];
  logic [12:0] seq [5] = '{13'h0000, 13'h1555, 13'h0AAA, 13'h1FFF, 13'h10F0};
  logic [7:0] flt = 8'h5A;
  logic busy = 1'b0;
  logic wsel = 1'b0;
  logic drv;
  logic wr_end;
  int step = 0;

  initial
  begin
    clashes = 0;
    foreach (nvm[i]) nvm[i] = 8'(i * 3 + 1);
  end
  // an undriven bus wanders, so a stale byte can never pass as read data
  always #8 flt = ~flt + 8'h13;
  assign drv = !mem.chip_en_n && !mem.out_en_n && mem.write_en_n && !busy
    && !wsel;
  assign data_pins_in = mem.data_pins_oe ? mem.data_pins_out
    : drv ? ram[mem.address_inputs] : flt;
  assign wr_end = mem.chip_en_n | mem.write_en_n;

  // a nonvolatile cycle runs alone; low supply refuses or cuts a store
  task automatic run_nv(input logic st);
    int t;
    busy = 1'b1;
    for (t = 0; t < (st ? STORE_NS : RECALL_NS) && (supply_ok || !st); t += 10)
      #10;
    if (!st && !wr_end)
      clashes++;
    if (!st)
      ram = nvm;
    else if (supply_ok)
      nvm = ram;
    busy = 1'b0;
  endtask : run_nv

  // recall on every supply rise
  always @(posedge supply_ok)
  begin
    fork
      run_nv(1'b0);
    join_none
  end
  // byte lands when the first strobe rises
  always @(posedge wr_end)
    if (!busy)
      ram[mem.address_inputs] = data_pins_in;
  // both sides driving at once
  always @(mem.data_pins_oe or drv)
    if (mem.data_pins_oe && drv)
      clashes++;
  // steps clocked by select; a write or stray address restarts
  always @(negedge mem.chip_en_n)
  begin
    wsel = !mem.write_en_n;
    if (busy)
      clashes++;
    else if (wsel)
      step = 0;
    else if (step == 5 && mem.address_inputs inside {13'h0F0F, 13'h0F0E})
    begin
      step = 0;
      fork
        run_nv(mem.address_inputs[0]);
      join_none
    end
    else if (step < 5 && mem.address_inputs == seq[step])
      step++;
    else
      step = int'(mem.address_inputs == 13'h0000);
  end
endmodule : nvsc_dev_model

/* File: verification/tb_nvsc_host.sv */
`timescale 1ns/1ps
module tb_nvsc_host;
  localparam int SC = 20;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic clk_en = 1'b1;
  logic req_valid = 1'b0;
  logic supply_ok = 1'b0;
  nvsc_pkg::nvsc_req_t req = '0;
  logic req_ready, rsp_valid, busy;
  logic [7:0] rsp_data, data_pins_in, d;
  logic [12:0] a;
  nvsc_pkg::nvsc_pins_t mem;
  int miscompares = 0;
  int checks = 0;
  int clashes, lat;
  logic [7:0] sram [8192];
  logic [7:0] nv [8192];

  nvsc_host #(.STORE_CYCLES(SC)) i_nvsc_host (.clk(clk), .rst_n(rst_n),
    .clk_en(clk_en), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .busy(busy), .supply_ok(supply_ok), .mem(mem),
    .data_pins_in(data_pins_in));
  nvsc_dev_model i_nvsc_dev_model (.mem(mem), .supply_ok(supply_ok),
    .data_pins_in(data_pins_in), .clashes(clashes));

  always #4 clk = ~clk;

  task automatic tally_and_finish();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic ok, input string msg);
    checks++;
    if (!ok)
    begin
      miscompares++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask : chk

  function automatic int exp_lat(input nvsc_pkg::nvsc_op_t o);
    if (o == nvsc_pkg::OP_READ)
      return nvsc_pkg::ACCESS_CYC + nvsc_pkg::OFF_CYC;
    if (o == nvsc_pkg::OP_WRITE)
      return nvsc_pkg::WRITE_CYC + nvsc_pkg::OFF_CYC;
    return 6 * (nvsc_pkg::ACCESS_CYC + nvsc_pkg::OFF_CYC) +
      (o == nvsc_pkg::OP_STORE ? SC : nvsc_pkg::RECALL_CYC);
  endfunction : exp_lat

  // bounded wait for ready, checked at falling edges where it is settled
  task automatic wait_ready();
    for (lat = 0; req_ready !== 1'b1 && lat < 3000; lat++)
      @(negedge clk);
    chk(lat < 3000, "ready never came");
    if (lat >= 3000)
      tally_and_finish();
  endtask : wait_ready

  // one request; clk_en may wander while it runs
  task automatic op(input nvsc_pkg::nvsc_op_t o, input logic [12:0] ad,
    input logic [7:0] wd, input logic stall);
    wait_ready();
    req = '{op: o, addr: ad, wdata: wd};
    req_valid = 1'b1;
    @(negedge clk);
    req_valid = 1'b0;
    chk(busy === 1'b1, "idle right after take");
    // stalls stop once the answer shows, so the next take runs free
    for (lat = 0; rsp_valid !== 1'b1 && lat < 3000; lat++)
    begin
      @(negedge clk);
      clk_en = (stall && rsp_valid !== 1'b1) ?
        1'($urandom_range(0, 1)) : 1'b1;
    end
    chk(lat < 3000, "no response");
    if (lat >= 3000)
      tally_and_finish();
    chk(busy === 1'b0, "busy with the answer");
    if (!stall)
      chk(lat == exp_lat(o), "latency");
  endtask : op

  task automatic rw(input logic wr, input logic stall);
    d = 8'($urandom);
    op(wr ? nvsc_pkg::OP_WRITE : nvsc_pkg::OP_READ, a, d, stall);
    if (wr)
      sram[a] = d;
    else
      chk(rsp_data === sram[a], "read data");
  endtask : rw

  task automatic powerup();
    wait_ready();
    chk(lat >= nvsc_pkg::RECALL_CYC, "early ready");
    sram = nv;
  endtask : powerup

  initial
  begin
    void'($urandom(12));
    foreach (nv[i]) nv[i] = 8'(i * 3 + 1);
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    supply_ok = 1'b1;
    powerup();
    // corner addresses, then random writes each read back
    for (int i = 0; i < 80; i++)
    begin
      if (!i[0] || i >= 60)
        a = i == 0 ? 13'h1FFF : i == 2 ? 13'h0000 : 13'($urandom);
      rw(i < 60 && !i[0], i > 40 && i < 60);
    end
    // store once, then three times over spoil a byte and recall it back
    op(nvsc_pkg::OP_STORE, 13'h0000, 8'h00, 1'b0);
    nv = sram;
    for (int j = 0; j < 3; j++)
    begin
      a = 13'($urandom);
      rw(1'b1, 1'b0);
      op(nvsc_pkg::OP_RECALL, 13'h0000, 8'h00, 1'b0);
      sram = nv;
      rw(1'b0, 1'b0);
    end
    // supply fails mid store: no answer, refusal, old bytes return
    a = 13'h0123;
    rw(1'b1, 1'b0);
    wait_ready();
    req = '{op: nvsc_pkg::OP_STORE, addr: 13'h0000, wdata: 8'h00};
    req_valid = 1'b1;
    @(negedge clk);
    req_valid = 1'b0;
    lat = 0;
    for (int n = 0; n < 92; n++)
    begin
      @(negedge clk);
      supply_ok = n < 62;
      lat += int'(rsp_valid === 1'b1);
    end
    chk(lat == 0 && req_ready === 1'b0, "store not cut off");
    @(negedge clk);
    supply_ok = 1'b1;
    powerup();
    rw(1'b0, 1'b0);
    chk(clashes == 0, "bus clash or access while busy");
    tally_and_finish();
  end
endmodule : tb_nvsc_host
